// File: include/cac_pkg.sv
// constants, register map and carrier types of the calendar alarm clock
package cac_pkg;

  // ==========================================================
  // register bus
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic we;
    logic re;
  } cac_req_t;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_CTL0 = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_CTL1 = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_SCMP = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_YEAR = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_MONTH = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_DAY = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_WEEK = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_HOUR = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_MIN = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_SEC = 6'h24;
  localparam logic [ADDR_W-1:0] OFS_ALW = 6'h28;
  localparam logic [ADDR_W-1:0] OFS_ALH = 6'h2C;
  localparam logic [ADDR_W-1:0] OFS_ALM = 6'h30;
  localparam logic [ADDR_W-1:0] OFS_CTL2 = 6'h34;
  localparam logic [ADDR_W-1:0] OFS_SUB = 6'h38;

  // ==========================================================
  // field positions
  localparam int CTL0_START_BIT = 4;
  localparam int CTL0_H24_BIT = 5;
  localparam int CTL1_CT_LSB = 0;
  localparam int CTL1_CT_W = 3;
  localparam int CTL1_SEC_IRQ_BIT = 3;
  localparam int CTL1_ALM_BIT = 4;
  localparam int CTL1_HZ_BIT = 5;
  localparam int CTL2_RUN_STOP_BIT = 0;
  localparam int CTL2_WAKE_BIT = 1;
  localparam int HOUR_PM_BIT = 5;

  // cycle interrupt period codes
  localparam logic [CTL1_CT_W-1:0] CT_SEC = 3'h3;
  localparam logic [CTL1_CT_W-1:0] CT_MIN = 3'h4;
  localparam logic [CTL1_CT_W-1:0] CT_HOUR = 3'h5;
  localparam logic [CTL1_CT_W-1:0] CT_DAY = 3'h6;
  localparam logic [CTL1_CT_W-1:0] CT_MONTH = 3'h7;

  // ==========================================================
  // reset values and bcd calendar limits
  localparam logic [7:0] CTL0_RST = 8'h00;
  localparam logic [7:0] CTL1_RST = 8'h00;
  localparam logic [7:0] CTL2_RST = 8'h00;
  localparam logic [31:0] SCMP_RST = 32'h0003_D3B4;
  localparam logic [7:0] ALW_RST = 8'h00;
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [7:0] LAST_SEC = 8'h59;
  localparam logic [7:0] LAST_HOUR24 = 8'h23;
  localparam logic [7:0] HOUR_ELEVEN = 8'h11;
  localparam logic [7:0] HOUR_NOON = 8'h12;
  localparam logic [7:0] LAST_MONTH = 8'h12;
  localparam logic [7:0] LAST_YEAR = 8'h99;
  localparam logic [7:0] LAST_WEEK = 8'h06;

  // calendar in two-digit bcd, week as 0..6
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] week;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } cac_time_t;

  localparam cac_time_t TIME_RST = '{
    year: 8'h00, month: 8'h01, day: 8'h01, week: 8'h00,
    hour: 8'h00, minute: 8'h00, second: 8'h00};

endpackage

// File: rtl/cac_clock.sv
// calendar alarm clock: bcd time keeping, alarm, one-second events
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/100ps

// Overview of operation
// - time advances once per second; pulse at that rate, cycle irq per second, minute, hour, day or month
// - control_first 0x10 starts counting in 12-hour format
// - control_first 0x30 starts counting in 24-hour format
// - control_second 0x33 enables pulse, alarm and 1 s cycle irq
// - sub-counter meets programmable compare value to mark each second
// - week count 0..6 with tuesday 2; alarm weekday is a bit mask
// - alarm irq when weekday, hour and minute match alarm settings
// - counting continues in stop mode when so configured
// - alarm event can request wakeup out of stop mode
// - separate one-second irq independent of cycle irq enable
module cac_clock (
  input wire logic core_clk,
  input wire logic rst,
  input wire cac_pkg::cac_req_t reg_req,
  output logic [cac_pkg::DATA_W-1:0] reg_rdata,
  input wire logic stop_mode,
  output logic cycle_irq,
  output logic one_second_irq,
  output logic alarm_irq,
  output logic one_hz_pulse_out,
  output logic wakeup_req
);
  import cac_pkg::*;

  // ==========================================================
  // helper functions

  // next bcd value, lower digit rolls at nine
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  // step with wrap: {carry, next}
  function automatic logic [8:0] bcd_step(input logic [7:0] v,
                                          input logic [7:0] last,
                                          input logic [7:0] first);
    bcd_step = (v == last) ? {1'b1, first} : {1'b0, bcd_inc(v)};
  endfunction

  // leap year on a bcd year of the century
  // the century is not kept, so year 00 is taken as a leap year
  function automatic logic bcd_leap(input logic [7:0] y);
    if (y[4]) begin
      bcd_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      bcd_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) ||
                 (y[3:0] == 4'h8);
    end
  endfunction

  // last day of the month in bcd
  function automatic logic [7:0] month_last(input logic [7:0] m,
                                            input logic [7:0] y);
    case (m)
      8'h02: month_last = bcd_leap(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
      default: month_last = 8'h31;
    endcase
  endfunction

  // 12-hour step: 11am->12pm, 12pm->1pm, 11pm->12am with day carry
  // pm flag in bit 5: 12-hour values run 0x01..0x12 and 0x21..0x32
  function automatic logic [8:0] hour12_step(input logic [7:0] h);
    logic pm;
    logic [7:0] hv;
    pm = h[HOUR_PM_BIT];
    hv = h & ~(8'h01 << HOUR_PM_BIT);
    if (hv == HOUR_ELEVEN) begin
      hour12_step = {pm, (pm ? HOUR_NOON : (HOUR_NOON | 8'h20))};
    end else if (hv == HOUR_NOON) begin
      hour12_step = {1'b0, (BCD_ONE | (h & 8'h20))};
    end else begin
      hour12_step = {1'b0, (bcd_inc(hv) | (h & 8'h20))};
    end
  endfunction

  // ==========================================================
  // state
  logic [7:0] ctl0_q, ctl0_d, ctl1_q, ctl1_d, ctl2_q, ctl2_d;
  logic [31:0] scmp_q, scmp_d, sub_q, sub_d;
  cac_time_t tm_q, tm_d;
  logic [7:0] alw_q, alw_d, alh_q, alh_d, alm_q, alm_d;
  logic match_q, match_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic cyc_q, cyc_d, sec_q, sec_d, alm_irq_q, alm_irq_d;
  logic hz_q, hz_d, wake_q, wake_d;

  logic run, sec_tick, min_c, hour_c, day_c, month_c;
  logic [8:0] s_sec, s_min, s_hour, s_day, s_mon, s_year;
  logic [CTL1_CT_W-1:0] ct;
  logic match, alarm_evt;

  // ==========================================================
  // time base and calendar cascade
  always_comb begin
    // counting enabled by start bit, held in stop unless told to run
    run = ctl0_q[CTL0_START_BIT] &&
          (!stop_mode || ctl2_q[CTL2_RUN_STOP_BIT]);
    sec_tick = run && (sub_q == scmp_q);
    // cleared while start is off, so a restart gives a whole first second;
    // held, not cleared, while stop mode pauses it
    if (!ctl0_q[CTL0_START_BIT]) begin
      sub_d = '0;
    end else if (!run) begin
      sub_d = sub_q;
    end else if (sec_tick) begin
      sub_d = '0;
    end else begin
      sub_d = sub_q + 32'h0000_0001;
    end

    s_sec = bcd_step(tm_q.second, LAST_SEC, BCD_ZERO);
    s_min = bcd_step(tm_q.minute, LAST_SEC, BCD_ZERO);
    if (ctl0_q[CTL0_H24_BIT]) begin
      s_hour = bcd_step(tm_q.hour, LAST_HOUR24, BCD_ZERO);
    end else begin
      s_hour = hour12_step(tm_q.hour);
    end
    s_day = bcd_step(tm_q.day, month_last(tm_q.month, tm_q.year),
                     BCD_ONE);
    s_mon = bcd_step(tm_q.month, LAST_MONTH, BCD_ONE);
    s_year = bcd_step(tm_q.year, LAST_YEAR, BCD_ZERO);

    min_c = sec_tick && s_sec[8];
    hour_c = min_c && s_min[8];
    day_c = hour_c && s_hour[8];
    month_c = day_c && s_day[8];

    tm_d = tm_q;
    if (sec_tick) begin
      tm_d.second = s_sec[7:0];
    end
    if (min_c) begin
      tm_d.minute = s_min[7:0];
    end
    if (hour_c) begin
      tm_d.hour = s_hour[7:0];
    end
    if (day_c) begin
      tm_d.day = s_day[7:0];
      tm_d.week = (tm_q.week >= LAST_WEEK) ? BCD_ZERO
                                           : tm_q.week + 8'h01;
    end
    if (month_c) begin
      tm_d.month = s_mon[7:0];
    end
    if (month_c && s_mon[8]) begin
      tm_d.year = s_year[7:0];
    end

    // software writes override the cascade in the same cycle; carries to
    // the upper fields still follow the old value, so software should
    // load the time with counting stopped
    ctl0_d = ctl0_q;
    ctl1_d = ctl1_q;
    ctl2_d = ctl2_q;
    scmp_d = scmp_q;
    alw_d = alw_q;
    alh_d = alh_q;
    alm_d = alm_q;
    if (reg_req.we) begin
      case (reg_req.addr)
        OFS_CTL0: ctl0_d = reg_req.wdata[7:0];
        OFS_CTL1: ctl1_d = reg_req.wdata[7:0];
        OFS_CTL2: ctl2_d = reg_req.wdata[7:0];
        OFS_SCMP: scmp_d = reg_req.wdata;
        OFS_YEAR: tm_d.year = reg_req.wdata[7:0];
        OFS_MONTH: tm_d.month = reg_req.wdata[7:0];
        OFS_DAY: tm_d.day = reg_req.wdata[7:0];
        OFS_WEEK: tm_d.week = reg_req.wdata[7:0];
        OFS_HOUR: tm_d.hour = reg_req.wdata[7:0];
        OFS_MIN: tm_d.minute = reg_req.wdata[7:0];
        OFS_SEC: tm_d.second = reg_req.wdata[7:0];
        OFS_ALW: alw_d = reg_req.wdata[7:0];
        OFS_ALH: alh_d = reg_req.wdata[7:0];
        OFS_ALM: alm_d = reg_req.wdata[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // events and output pulses
  always_comb begin
    ct = ctl1_q[CTL1_CT_LSB +: CTL1_CT_W];
    case (ct)
      CT_SEC: cyc_d = sec_tick;
      CT_MIN: cyc_d = min_c;
      CT_HOUR: cyc_d = hour_c;
      CT_DAY: cyc_d = day_c;
      CT_MONTH: cyc_d = month_c;
      default: cyc_d = 1'b0;
    endcase
    sec_d = sec_tick && ctl1_q[CTL1_SEC_IRQ_BIT];
    // weekday mask bit selected by current week count; a week value above
    // six never matches, so a bad write cannot index past the mask
    match = (tm_q.week <= LAST_WEEK) && alw_q[tm_q.week[2:0]] &&
            (tm_q.hour == alh_q) && (tm_q.minute == alm_q);
    // the registered match turns a long match into a single event, which
    // is consumed even while both the irq and the wakeup are disabled
    match_d = match;
    alarm_evt = match && !match_q;
    alm_irq_d = alarm_evt && ctl1_q[CTL1_ALM_BIT];
    wake_d = alarm_evt && ctl2_q[CTL2_WAKE_BIT];
    // high for the first half of each second; the split follows the
    // compare value, so the duty stays near half for any nonzero setting
    hz_d = ctl1_q[CTL1_HZ_BIT] && run &&
           (sub_q <= (scmp_q >> 1));
  end

  // ==========================================================
  // register read mux, data one cycle after the strobe
  // the data stand for that one cycle only; otherwise the port reads zero
  always_comb begin
    rdata_d = '0;
    if (reg_req.re) begin
      case (reg_req.addr)
        OFS_CTL0: rdata_d = {24'h00_0000, ctl0_q};
        OFS_CTL1: rdata_d = {24'h00_0000, ctl1_q};
        OFS_CTL2: rdata_d = {24'h00_0000, ctl2_q};
        OFS_SCMP: rdata_d = scmp_q;
        OFS_YEAR: rdata_d = {24'h00_0000, tm_q.year};
        OFS_MONTH: rdata_d = {24'h00_0000, tm_q.month};
        OFS_DAY: rdata_d = {24'h00_0000, tm_q.day};
        OFS_WEEK: rdata_d = {24'h00_0000, tm_q.week};
        OFS_HOUR: rdata_d = {24'h00_0000, tm_q.hour};
        OFS_MIN: rdata_d = {24'h00_0000, tm_q.minute};
        OFS_SEC: rdata_d = {24'h00_0000, tm_q.second};
        OFS_ALW: rdata_d = {24'h00_0000, alw_q};
        OFS_ALH: rdata_d = {24'h00_0000, alh_q};
        OFS_ALM: rdata_d = {24'h00_0000, alm_q};
        OFS_SUB: rdata_d = sub_q;
        default: rdata_d = '0;
      endcase
    end
  end

  // ==========================================================
  // time base and register file state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctl0_q <= CTL0_RST;
      ctl1_q <= CTL1_RST;
      ctl2_q <= CTL2_RST;
      scmp_q <= SCMP_RST;
      sub_q <= '0;
      tm_q <= TIME_RST;
      alw_q <= ALW_RST;
      alh_q <= BCD_ZERO;
      alm_q <= BCD_ZERO;
    end else begin
      ctl0_q <= ctl0_d;
      ctl1_q <= ctl1_d;
      ctl2_q <= ctl2_d;
      scmp_q <= scmp_d;
      sub_q <= sub_d;
      tm_q <= tm_d;
      alw_q <= alw_d;
      alh_q <= alh_d;
      alm_q <= alm_d;
    end
  end

  // event state and the registered event outputs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      match_q <= 1'b0;
      cyc_q <= 1'b0;
      sec_q <= 1'b0;
      alm_irq_q <= 1'b0;
      hz_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      match_q <= match_d;
      cyc_q <= cyc_d;
      sec_q <= sec_d;
      alm_irq_q <= alm_irq_d;
      hz_q <= hz_d;
      wake_q <= wake_d;
    end
  end

  // read data register, zero outside the read slot
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata = rdata_q;
  assign cycle_irq = cyc_q;
  assign one_second_irq = sec_q;
  assign alarm_irq = alm_irq_q;
  assign one_hz_pulse_out = hz_q;
  assign wakeup_req = wake_q;

endmodule

// File: sim/cac_clock_asserts.sv
// port-level assertion checker of the calendar alarm clock
`timescale 1ns/100ps
module cac_clock_asserts (
  input wire logic core_clk,
  input wire logic rst,
  input wire cac_pkg::cac_req_t reg_req,
  input wire logic [cac_pkg::DATA_W-1:0] reg_rdata,
  input wire logic stop_mode,
  input wire logic cycle_irq,
  input wire logic one_second_irq,
  input wire logic alarm_irq,
  input wire logic one_hz_pulse_out,
  input wire logic wakeup_req
);
  import cac_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // shadow copies of the enable bits seen on the bus
  logic run_q, sec_q, alm_q, hz_q, wk_q;
  logic [2:0] ct_q;
  // tracks writes to the three control registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      {run_q, sec_q, alm_q, hz_q, wk_q, ct_q} <= '0;
    end else if (reg_req.we) begin
      if (reg_req.addr == OFS_CTL0) begin
        run_q <= reg_req.wdata[CTL0_START_BIT];
      end
      if (reg_req.addr == OFS_CTL1) begin
        {hz_q, alm_q, sec_q, ct_q} <= reg_req.wdata[5:0];
      end
      if (reg_req.addr == OFS_CTL2) begin
        wk_q <= reg_req.wdata[CTL2_WAKE_BIT];
      end
    end
  end
  // ==========================================================
  // properties
  a_rdata_idle: assert property (!reg_req.re |=> reg_rdata == '0)
    else $error("read data not zero outside read slot");
  a_reset_quiet: assert property ($past(rst) |-> !(cycle_irq
    || one_second_irq || alarm_irq || wakeup_req || one_hz_pulse_out))
    else $error("output active right after reset");
  a_alarm_once: assert property (alarm_irq |=> !alarm_irq)
    else $error("alarm pulse longer than one cycle");
  a_wake_once: assert property (wakeup_req |=> !wakeup_req)
    else $error("wakeup pulse longer than one cycle");
  a_alarm_gate: assert property (!alm_q [*3] |-> !alarm_irq)
    else $error("alarm pulse while disabled");
  a_wake_gate: assert property (!wk_q [*3] |-> !wakeup_req)
    else $error("wakeup pulse while disabled");
  a_second_gate: assert property (!sec_q [*3] |-> !one_second_irq)
    else $error("second pulse while disabled");
  a_pulse_gate: assert property (!hz_q [*3] |-> !one_hz_pulse_out)
    else $error("pulse output while disabled");
  a_halt_quiet: assert property (!run_q [*3] |->
    !(one_second_irq || cycle_irq))
    else $error("second event while stopped");
  a_tick_pair: assert property ((sec_q && ct_q == CT_SEC) [*3]
    |-> one_second_irq == cycle_irq)
    else $error("cycle and second pulses disagree");
  a_alarm_wake: assert property ((alm_q && wk_q) [*3]
    |-> alarm_irq == wakeup_req)
    else $error("alarm and wakeup pulses disagree");
endmodule

bind cac_clock cac_clock_asserts cac_clock_asserts_i (.core_clk(core_clk),
  .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .stop_mode(stop_mode), .cycle_irq(cycle_irq),
  .one_second_irq(one_second_irq), .alarm_irq(alarm_irq),
  .one_hz_pulse_out(one_hz_pulse_out), .wakeup_req(wakeup_req));

// File: sim/cac_clock_tb_top.sv
// self-checking testbench of the calendar alarm clock
`timescale 1ns/100ps
module cac_clock_tb_top;
  import cac_pkg::*;
  logic core_clk, rst, stop_mode;
  cac_req_t reg_req;
  logic [DATA_W-1:0] reg_rdata;
  logic cycle_irq, one_second_irq, alarm_irq, one_hz_pulse_out, wakeup_req;
  int n_mismatch = 0;
  int n_checks = 0;
  cac_clock cac_clock_i (.core_clk(core_clk), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .stop_mode(stop_mode), .cycle_irq(cycle_irq),
    .one_second_irq(one_second_irq), .alarm_irq(alarm_irq),
    .one_hz_pulse_out(one_hz_pulse_out), .wakeup_req(wakeup_req));
  // 250 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // ==========================================================
  // shared tasks
  task automatic summarize();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s: %h not %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge core_clk);
    reg_req.we <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp,
                    input string what);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: 32'h0000_0000, we: 1'b0, re: 1'b1};
    @(posedge core_clk);
    reg_req.re <= 1'b0;
    #1;
    chk(reg_rdata, exp, what);
  endtask
  // picks an observed output by number; 1 gives alarm and wakeup together
  function automatic logic pick(input int sel);
    case (sel)
      0: return one_second_irq;
      1: return alarm_irq && wakeup_req;
      2: return cycle_irq;
      default: return one_hz_pulse_out;
    endcase
  endfunction
  // waits for a pulse, bounded; returns the cycles taken
  task automatic wait_hi(input int sel, lim, output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (pick(sel) !== 1'b1 && n < lim);
    if (pick(sel) !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED %0t wait timed out", $time);
      summarize();
    end
  endtask
  // counts high cycles of an output over a window
  task automatic watch(input int sel, cyc, output int hi);
    hi = 0;
    repeat (cyc) begin
      @(posedge core_clk);
      #1;
      hi += (pick(sel) === 1'b1);
    end
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd(OFS_SCMP, 32'h0003_D3B4, "compare reset");
    rd(OFS_MONTH, 32'h0000_0001, "month reset");
    wr(6'h3C, 32'h0000_00FF);
    rd(6'h3C, 32'h0000_0000, "unmapped read");
  endtask
  task automatic t_12h();
    int n;
    wr(OFS_SCMP, 32'h0000_0003);
    wr(OFS_HOUR, 32'h0000_0011);
    wr(OFS_MIN, 32'h0000_0059);
    wr(OFS_SEC, 32'h0000_0059);
    wr(OFS_CTL1, 32'h0000_0033);
    wr(OFS_CTL0, 32'h0000_0010);
    wait_hi(2, 12, n);
    rd(OFS_HOUR, 32'h0000_0032, "noon in 12h");
    rd(OFS_MIN, 32'h0000_0000, "minute wrap");
    wait_hi(2, 12, n);
    wait_hi(2, 12, n);
    chk(n, 4, "second period");
    watch(3, 8, n);
    chk(n, 4, "pulse duty");
  endtask
  task automatic t_24h();
    int n;
    wr(OFS_CTL0, 32'h0000_0000);
    wr(OFS_HOUR, 32'h0000_0012);
    wr(OFS_MIN, 32'h0000_0059);
    wr(OFS_SEC, 32'h0000_0059);
    wr(OFS_CTL1, 32'h0000_003B);
    wr(OFS_CTL0, 32'h0000_0030);
    wait_hi(0, 12, n);
    rd(OFS_HOUR, 32'h0000_0013, "13h in 24h");
  endtask
  task automatic t_alarm();
    int n;
    wr(OFS_CTL0, 32'h0000_0000);
    wr(OFS_CTL1, 32'h0000_0018);
    wr(OFS_CTL2, 32'h0000_0002);
    wr(OFS_WEEK, 32'h0000_0002);
    wr(OFS_HOUR, 32'h0000_0008);
    wr(OFS_MIN, 32'h0000_0008);
    wr(OFS_SEC, 32'h0000_0059);
    wr(OFS_ALW, 32'h0000_0004);
    wr(OFS_ALH, 32'h0000_0008);
    wr(OFS_ALM, 32'h0000_0009);
    wr(OFS_CTL0, 32'h0000_0030);
    wait_hi(0, 12, n);
    watch(1, 40, n);
    chk(n, 1, "alarm with wakeup once");
    watch(2, 8, n);
    chk(n, 0, "cycle irq off");
    rd(OFS_MIN, 32'h0000_0009, "alarm minute");
  endtask
  task automatic t_stop();
    int n;
    @(posedge core_clk);
    stop_mode <= 1'b1;
    wr(OFS_CTL2, 32'h0000_0001);
    wait_hi(0, 12, n);
    chk(n <= 4, 1, "runs in stop");
    wr(OFS_CTL2, 32'h0000_0000);
    watch(0, 12, n);
    chk(n, 0, "held in stop");
    @(posedge core_clk);
    stop_mode <= 1'b0;
    wait_hi(0, 12, n);
  endtask
  // calendar carries and the month, day, hour and minute cycle interrupt period codes
  task automatic t_carry();
    int n;
    wr(OFS_CTL0, 32'h0000_0000);
    wr(OFS_CTL1, 32'(CT_MONTH));
    wr(OFS_YEAR, 32'h0000_0023);
    wr(OFS_MONTH, 32'h0000_0008);
    wr(OFS_DAY, 32'h0000_0031);
    wr(OFS_WEEK, 32'h0000_0006);
    wr(OFS_HOUR, 32'h0000_0031);
    wr(OFS_MIN, 32'h0000_0059);
    wr(OFS_SEC, 32'h0000_0059);
    wr(OFS_CTL0, 32'h0000_0010);
    wait_hi(2, 12, n);
    rd(OFS_HOUR, 32'h0000_0012, "midnight in 12h");
    rd(OFS_DAY, 32'h0000_0001, "month end");
    rd(OFS_MONTH, 32'h0000_0009, "month carry");
    rd(OFS_WEEK, 32'h0000_0000, "week wrap");
    rd(OFS_YEAR, 32'h0000_0023, "year kept");
    watch(2, 8, n);
    chk(n, 0, "month code on plain second");
    wr(OFS_CTL0, 32'h0000_0000);
    wr(OFS_CTL1, 32'(CT_DAY));
    wr(OFS_YEAR, 32'h0000_0024);
    wr(OFS_MONTH, 32'h0000_0002);
    wr(OFS_DAY, 32'h0000_0028);
    wr(OFS_HOUR, 32'h0000_0023);
    wr(OFS_MIN, 32'h0000_0059);
    wr(OFS_SEC, 32'h0000_0059);
    wr(OFS_CTL0, 32'h0000_0030);
    wait_hi(2, 12, n);
    rd(OFS_DAY, 32'h0000_0029, "leap day");
    wr(OFS_CTL1, 32'(CT_HOUR));
    wr(OFS_MIN, 32'h0000_0059);
    wr(OFS_SEC, 32'h0000_0059);
    wait_hi(2, 12, n);
    rd(OFS_HOUR, 32'h0000_0001, "hour carry");
    wr(OFS_CTL1, 32'(CT_MIN));
    wr(OFS_SEC, 32'h0000_0059);
    wait_hi(2, 12, n);
    rd(OFS_MIN, 32'h0000_0001, "minute carry");
  endtask
  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    stop_mode = 1'b0;
    reg_req = '0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_12h();
    t_24h();
    t_alarm();
    t_stop();
    t_carry();
    summarize();
  end
endmodule
